// [pkg/amt_pkg.sv]
package amt_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CMD = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_OFS_A = 4'h3;
  localparam logic [3:0] ADDR_OFS_B = 4'h4;
  localparam logic [3:0] ADDR_FREQ = 4'h5;
  localparam logic [3:0] ADDR_ACQ_CNT = 4'h6;
  localparam logic [3:0] ADDR_SAVE_CNT = 4'h7;
  // ctrl fields
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_FALL_BIT = 4;
  localparam int CTRL_DISP_LSB = 5;
  localparam int CTRL_Y5_BIT = 9;
  localparam int CTRL_ADD_BIT = 10;
  localparam int CTRL_INVA_BIT = 11;
  localparam int CTRL_INVB_BIT = 12;
  localparam int CTRL_HOLD_LSB = 16;
  // cmd fields
  localparam int CMD_LOCK_BIT = 0;
  localparam int CMD_WRITE_BIT = 1;
  localparam int CMD_CLEAR_BIT = 2;
  localparam int CMD_SAVE_BIT = 3;
  localparam int CMD_DEST_LSB = 4;
  localparam int CMD_OFS_OP_LSB = 8;
  localparam int CMD_OFS_CH_BIT = 10;
  localparam int CMD_OFS_VAL_LSB = 16;
  // offset operations
  localparam logic [1:0] OFS_UP1 = 2'h0;
  localparam logic [1:0] OFS_DN1 = 2'h1;
  localparam logic [1:0] OFS_STEP10 = 2'h2;
  localparam logic [1:0] OFS_SET = 2'h3;
  localparam logic signed [15:0] OFS_DIV = 16'sh0001;
  localparam logic signed [15:0] OFS_SCREEN = 16'sh000A;
  // trigger
  localparam logic [6:0] PRESCALE_LAST = 7'h7F;
  localparam logic [15:0] FREQ_UP_MHZ = 16'h00A0;
  localparam logic [15:0] FREQ_DN_MHZ = 16'h0096;
  localparam logic [15:0] HOLD_RESET = 16'h0000;
  localparam logic [3:0] DISP_RESET = 4'h1;
  typedef enum logic [1:0] {
    SRC_A = 2'h0, SRC_B = 2'h1, SRC_EXT = 2'h2
  } amt_src_e;
  typedef enum logic [1:0] {
    MODE_DIRECT = 2'h0, MODE_PRESCALED = 2'h1,
    MODE_SYNC = 2'h2, MODE_AUTO = 2'h3
  } amt_mode_e;
  typedef enum logic [1:0] {
    ST_WRITE = 2'h0, ST_LOCK = 2'h1
  } amt_mem_e;
  typedef struct packed {
    logic trig_a;
    logic trig_b;
    logic trig_ext;
  } amt_trig_s;
  typedef struct packed {
    logic [3:0] disp_en;
    logic y5;
    logic add;
    logic diff;
  } amt_disp_s;
endpackage

// [hw/amt_core.sv]
`timescale 1ns/1ps
// Functional notes
// - four wave registers, each holding a channel A and a channel B record
// - new acquisitions are written into wave_reg_zero only
// - save copies wave_reg_zero into any selected subset of one to three
// - any subset of registers may be enabled for display, overlaid
// - y/5 mode separates the four registers vertically
// - lock state blocks every new acquisition
// - write command leaves lock and re-enables acquisition
// - clear empties wave_reg_zero only in write mode; ignored when locked
// - registers one to three are blanked only by reset or by saving a cleared zero
// - per-channel offset, steps of one or ten divisions, or set value
// - add mode sums the two channels into one waveform
// - add mode with exactly one channel inverted gives the difference
// - trigger source is channel A, channel B or external input
// - acquisition starts on the comparator trigger pulse
// - falling slope selected starts on falling crossing, else rising
// - falling slope accepted only in direct edge trigger mode
// - prescaled mode divides the trigger by 128
// - free sync mode uses the holdoff sync adjustment to stabilise
// - auto mode goes prescaled above 160 MHz, back below 150 MHz
module amt_core (
  input wire logic clock,
  input wire logic reset,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic trig_a,
  input wire logic trig_b,
  input wire logic trig_ext,
  input wire logic [15:0] freq_mhz,
  input wire logic [15:0] sample_a,
  input wire logic [15:0] sample_b,
  output logic acq_start,
  output logic [1:0] trig_src,
  output logic eff_prescaled,
  output logic [15:0] holdoff_sync_adjust,
  output amt_pkg::amt_disp_s disp,
  output logic signed [15:0] ofs_a,
  output logic signed [15:0] ofs_b,
  output logic [15:0] wave_a [4],
  output logic [15:0] wave_b [4],
  output logic [3:0] wave_valid,
  output logic [16:0] sum_wave
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  amt_pkg::amt_trig_s trig_s1_q, trig_s2_q, trig_s3_q;
  amt_pkg::amt_trig_s trig_s1_d, trig_s2_d, trig_s3_d;
  logic [15:0] freq_s1_q, freq_s2_q, freq_s1_d, freq_s2_d;
  logic [15:0] freq_s3_q, freq_s3_d, freq_q, freq_d;

  always_comb begin
    trig_s1_d = '{trig_a: trig_a, trig_b: trig_b, trig_ext: trig_ext};
    trig_s2_d = trig_s1_q;
    trig_s3_d = trig_s2_q;
    freq_s1_d = freq_mhz;
    freq_s2_d = freq_s1_q;
    freq_s3_d = freq_s2_q;
    // a multi-bit word may be caught mid-change; take it only once it
    // has read the same on two edges in a row
    freq_d = (freq_s2_q == freq_s3_q) ? freq_s2_q : freq_q;
  end

  always_ff @(posedge clock) begin
    trig_s1_q <= trig_s1_d;
    trig_s2_q <= trig_s2_d;
    trig_s3_q <= trig_s3_d;
    freq_s1_q <= freq_s1_d;
    freq_s2_q <= freq_s2_d;
    freq_s3_q <= freq_s3_d;
    freq_q <= freq_d;
  end

  // ****************************************
  // configuration registers
  // ****************************************
  logic [1:0] src_q, src_d;
  logic [1:0] mode_q, mode_d;
  logic fall_q, fall_d;
  logic [3:0] disp_q, disp_d;
  logic y5_q, y5_d, add_q, add_d, inva_q, inva_d, invb_q, invb_d;
  logic [15:0] hold_q, hold_d;
  logic signed [15:0] ofs_a_q, ofs_a_d, ofs_b_q, ofs_b_d;
  logic auto_pre_q, auto_pre_d;
  logic cmd_wr;

  function automatic logic signed [15:0] ofs_next(
    input logic signed [15:0] cur,
    input logic [1:0] op,
    input logic dn,
    input logic [15:0] val
  );
    logic signed [15:0] r;
    r = cur;
    unique case (op)
      amt_pkg::OFS_UP1: r = cur + amt_pkg::OFS_DIV;
      amt_pkg::OFS_DN1: r = cur - amt_pkg::OFS_DIV;
      amt_pkg::OFS_STEP10: r = dn ? cur - amt_pkg::OFS_SCREEN
                                  : cur + amt_pkg::OFS_SCREEN;
      amt_pkg::OFS_SET: r = $signed(val);
    endcase
    return r;
  endfunction

  assign cmd_wr = wr && (addr == amt_pkg::ADDR_CMD);

  always_comb begin
    src_d = src_q;
    mode_d = mode_q;
    fall_d = fall_q;
    disp_d = disp_q;
    y5_d = y5_q;
    add_d = add_q;
    inva_d = inva_q;
    invb_d = invb_q;
    hold_d = hold_q;
    ofs_a_d = ofs_a_q;
    ofs_b_d = ofs_b_q;
    if (wr && addr == amt_pkg::ADDR_CTRL) begin
      // unused source code falls back to channel A
      src_d = (wdata[amt_pkg::CTRL_SRC_LSB +: 2] == 2'h3) ? 2'h0
            : wdata[amt_pkg::CTRL_SRC_LSB +: 2];
      mode_d = wdata[amt_pkg::CTRL_MODE_LSB +: 2];
      // slope bit is dropped unless the new mode is direct edge
      fall_d = wdata[amt_pkg::CTRL_FALL_BIT] &&
               (wdata[amt_pkg::CTRL_MODE_LSB +: 2] ==
                amt_pkg::MODE_DIRECT);
      disp_d = wdata[amt_pkg::CTRL_DISP_LSB +: 4];
      y5_d = wdata[amt_pkg::CTRL_Y5_BIT];
      add_d = wdata[amt_pkg::CTRL_ADD_BIT];
      inva_d = wdata[amt_pkg::CTRL_INVA_BIT];
      invb_d = wdata[amt_pkg::CTRL_INVB_BIT];
      hold_d = wdata[amt_pkg::CTRL_HOLD_LSB +: 16];
    end
    if (cmd_wr) begin
      if (!wdata[amt_pkg::CMD_OFS_CH_BIT]) begin
        ofs_a_d = ofs_next(ofs_a_q, wdata[amt_pkg::CMD_OFS_OP_LSB +: 2],
                           wdata[amt_pkg::CMD_OFS_VAL_LSB + 15],
                           wdata[amt_pkg::CMD_OFS_VAL_LSB +: 16]);
      end else begin
        ofs_b_d = ofs_next(ofs_b_q, wdata[amt_pkg::CMD_OFS_OP_LSB +: 2],
                           wdata[amt_pkg::CMD_OFS_VAL_LSB + 15],
                           wdata[amt_pkg::CMD_OFS_VAL_LSB +: 16]);
      end
    end
  end

  // ****************************************
  // automatic mode hysteresis
  // ****************************************
  always_comb begin
    auto_pre_d = auto_pre_q;
    if (!auto_pre_q && freq_q > amt_pkg::FREQ_UP_MHZ) begin
      auto_pre_d = 1'b1;
    end else if (auto_pre_q && freq_q < amt_pkg::FREQ_DN_MHZ) begin
      auto_pre_d = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      src_q <= 2'h0;
      mode_q <= 2'h0;
      fall_q <= 1'b0;
      disp_q <= amt_pkg::DISP_RESET;
      y5_q <= 1'b0;
      add_q <= 1'b0;
      inva_q <= 1'b0;
      invb_q <= 1'b0;
      hold_q <= amt_pkg::HOLD_RESET;
      ofs_a_q <= 16'sh0000;
      ofs_b_q <= 16'sh0000;
      auto_pre_q <= 1'b0;
    end else begin
      src_q <= src_d;
      mode_q <= mode_d;
      fall_q <= fall_d;
      disp_q <= disp_d;
      y5_q <= y5_d;
      add_q <= add_d;
      inva_q <= inva_d;
      invb_q <= invb_d;
      hold_q <= hold_d;
      ofs_a_q <= ofs_a_d;
      ofs_b_q <= ofs_b_d;
      auto_pre_q <= auto_pre_d;
    end
  end

  // ****************************************
  // trigger path
  // ****************************************
  logic pre_mode, sync_mode, trig_cur, trig_prev, edge_hit, trig_evt;
  logic [6:0] pre_cnt_q, pre_cnt_d;

  always_comb begin
    unique case (src_q)
      amt_pkg::SRC_B: begin
        trig_cur = trig_s2_q.trig_b;
        trig_prev = trig_s3_q.trig_b;
      end
      amt_pkg::SRC_EXT: begin
        trig_cur = trig_s2_q.trig_ext;
        trig_prev = trig_s3_q.trig_ext;
      end
      default: begin
        trig_cur = trig_s2_q.trig_a;
        trig_prev = trig_s3_q.trig_a;
      end
    endcase
    pre_mode = (mode_q == amt_pkg::MODE_PRESCALED) ||
               (mode_q == amt_pkg::MODE_AUTO && auto_pre_q);
    sync_mode = (mode_q == amt_pkg::MODE_SYNC);
    edge_hit = fall_q ? (trig_prev && !trig_cur)
                      : (!trig_prev && trig_cur);
    pre_cnt_d = pre_cnt_q;
    if (pre_mode && edge_hit) begin
      pre_cnt_d = pre_cnt_q + 7'h01;
    end
    trig_evt = edge_hit && !sync_mode &&
               (!pre_mode || pre_cnt_q == amt_pkg::PRESCALE_LAST);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pre_cnt_q <= 7'h00;
    end else begin
      pre_cnt_q <= pre_cnt_d;
    end
  end

  // ****************************************
  // memory state and wave registers
  // ****************************************
  amt_pkg::amt_mem_e mem_q, mem_d;
  logic [15:0] wa_q [4], wa_d [4], wb_q [4], wb_d [4];
  logic [3:0] val_q, val_d;
  logic start_q, start_d;
  logic [15:0] acq_cnt_q, acq_cnt_d, save_cnt_q, save_cnt_d;

  always_comb begin
    mem_d = mem_q;
    wa_d = wa_q;
    wb_d = wb_q;
    val_d = val_q;
    acq_cnt_d = acq_cnt_q;
    save_cnt_d = save_cnt_q;
    start_d = 1'b0;
    if (cmd_wr && wdata[amt_pkg::CMD_WRITE_BIT]) begin
      mem_d = amt_pkg::ST_WRITE;
    end else if (cmd_wr && wdata[amt_pkg::CMD_LOCK_BIT]) begin
      mem_d = amt_pkg::ST_LOCK;
    end
    if (cmd_wr && wdata[amt_pkg::CMD_CLEAR_BIT] &&
        mem_q == amt_pkg::ST_WRITE) begin
      wa_d[0] = 16'h0000;
      wb_d[0] = 16'h0000;
      val_d[0] = 1'b0;
    end
    // a commit beside a clear wins, so a fresh record is never lost
    // a trigger in lock is dropped, not deferred
    if (trig_evt && mem_q == amt_pkg::ST_WRITE) begin
      wa_d[0] = sample_a;
      wb_d[0] = sample_b;
      val_d[0] = 1'b1;
      start_d = 1'b1;
      acq_cnt_d = acq_cnt_q + 16'h0001;
    end
    if (cmd_wr && wdata[amt_pkg::CMD_SAVE_BIT]) begin
      // copies the pre-edge contents of zero; zero itself is untouched
      for (int i = 1; i < 4; i++) begin
        if (wdata[amt_pkg::CMD_DEST_LSB + i - 1]) begin
          wa_d[i] = wa_q[0];
          wb_d[i] = wb_q[0];
          val_d[i] = val_q[0];
        end
      end
      save_cnt_d = save_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      mem_q <= amt_pkg::ST_WRITE;
      for (int i = 0; i < 4; i++) begin
        wa_q[i] <= 16'h0000;
        wb_q[i] <= 16'h0000;
      end
      val_q <= 4'h0;
      start_q <= 1'b0;
      acq_cnt_q <= 16'h0000;
      save_cnt_q <= 16'h0000;
    end else begin
      mem_q <= mem_d;
      wa_q <= wa_d;
      wb_q <= wb_d;
      val_q <= val_d;
      start_q <= start_d;
      acq_cnt_q <= acq_cnt_d;
      save_cnt_q <= save_cnt_d;
    end
  end

  // ****************************************
  // display combine and read-back
  // ****************************************
  amt_pkg::amt_disp_s disp_d2, disp_q2;
  logic [16:0] sum_q, sum_d;
  logic [31:0] rdata_q, rdata_d;

  always_comb begin
    disp_d2 = '{disp_en: disp_q, y5: y5_q, add: add_q,
                diff: add_q && (inva_q ^ invb_q)};
    sum_d = 17'h00000;
    if (add_q) begin
      // registered sum of zero; sign handling left to the display
      sum_d = (inva_q ^ invb_q)
            ? (inva_q ? {1'b0, wb_q[0]} - {1'b0, wa_q[0]}
                      : {1'b0, wa_q[0]} - {1'b0, wb_q[0]})
            : {1'b0, wa_q[0]} + {1'b0, wb_q[0]};
    end
    rdata_d = 32'h00000000;
    if (rd) begin
      unique case (addr)
        amt_pkg::ADDR_CTRL: rdata_d = {hold_q, 3'h0, invb_q, inva_q,
                                       add_q, y5_q, disp_q, fall_q,
                                       mode_q, src_q};
        amt_pkg::ADDR_STATUS: rdata_d = {24'h000000, val_q, 1'b0,
                                         pre_mode, auto_pre_q,
                                         mem_q == amt_pkg::ST_LOCK};
        amt_pkg::ADDR_OFS_A: rdata_d = {16'h0000, ofs_a_q};
        amt_pkg::ADDR_OFS_B: rdata_d = {16'h0000, ofs_b_q};
        amt_pkg::ADDR_FREQ: rdata_d = {16'h0000, freq_q};
        amt_pkg::ADDR_ACQ_CNT: rdata_d = {16'h0000, acq_cnt_q};
        amt_pkg::ADDR_SAVE_CNT: rdata_d = {16'h0000, save_cnt_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      disp_q2 <= '0;
      sum_q <= 17'h00000;
      rdata_q <= 32'h00000000;
    end else begin
      disp_q2 <= disp_d2;
      sum_q <= sum_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;
  assign acq_start = start_q;
  assign trig_src = src_q;
  assign eff_prescaled = auto_pre_q;
  assign holdoff_sync_adjust = hold_q;
  assign disp = disp_q2;
  assign ofs_a = ofs_a_q;
  assign ofs_b = ofs_b_q;
  assign wave_a = wa_q;
  assign wave_b = wb_q;
  assign wave_valid = val_q;
  assign sum_wave = sum_q;
endmodule

// [bench/amt_core_chk.sv]
`timescale 1ns/1ps
// ****
// memory and trigger checks
// ****
module amt_core_chk (
  input wire logic clock,
  input wire logic reset,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic acq_start,
  input wire logic [1:0] trig_src,
  input wire logic eff_prescaled,
  input wire amt_pkg::amt_disp_s disp,
  input wire logic [15:0] freq_mhz,
  input wire logic [15:0] wave_a [4],
  input wire logic [15:0] wave_b [4],
  input wire logic [3:0] wave_valid
);
  logic cmd, ctl, dif, sv, up, band;
  logic [1:0] md_q, md_d;
  logic [3:0] lk_q, lk_d, hi_q, hi_d, bd_q, bd_d;
  assign cmd = wr && addr == amt_pkg::ADDR_CMD;
  assign ctl = wr && addr == amt_pkg::ADDR_CTRL;
  assign dif = wdata[10] && (wdata[11] ^ wdata[12]);
  assign sv = cmd && wdata[3];
  assign up = freq_mhz > amt_pkg::FREQ_UP_MHZ;
  assign band = !up && freq_mhz >= amt_pkg::FREQ_DN_MHZ;
  // counters saturate so a long lock or plateau cannot wrap
  always_comb begin
    md_d = ctl ? wdata[3:2] : md_q;
    lk_d = lk_q + {3'h0, lk_q != 4'h0 && lk_q != 4'hF};
    if (cmd && wdata[1])
      lk_d = 4'h0;
    else if (cmd && wdata[0])
      lk_d = 4'h1;
    hi_d = (md_q == 2'h3 && up) ? hi_q + {3'h0, hi_q != 4'hF} : 4'h0;
    bd_d = (md_q == 2'h3 && band) ? bd_q + {3'h0, bd_q != 4'hF} : 4'h0;
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      md_q <= 2'h0;
      lk_q <= 4'h0;
      hi_q <= 4'h0;
      bd_q <= 4'h0;
    end else begin
      md_q <= md_d;
      lk_q <= lk_d;
      hi_q <= hi_d;
      bd_q <= bd_d;
    end
  end
  // a trigger just before lock may still land; allow for the sync delay
  property p_lock;
    @(posedge clock) disable iff (reset) lk_q > 4'h5 |-> !acq_start;
  endproperty
  a_lock: assert property (p_lock)
    else $error("commit while locked");
  property p_keep;
    @(posedge clock) disable iff (reset)
      !$past(sv) |-> $stable(wave_valid[3:1]) && $stable(wave_a[3]);
  endproperty
  a_keep: assert property (p_keep)
    else $error("upper register changed without save");
  property p_save;
    @(posedge clock) disable iff (reset) sv && wdata[4] |=>
      wave_a[1] == $past(wave_a[0]) && wave_b[1] == $past(wave_b[0]);
  endproperty
  a_save: assert property (p_save)
    else $error("save did not copy register zero");
  property p_clr;
    @(posedge clock) disable iff (reset)
      lk_q > 4'h5 && cmd && wdata[2] && !wdata[1] |=> $stable(wave_valid[0]);
  endproperty
  a_clr: assert property (p_clr)
    else $error("clear acted while locked");
  property p_src;
    @(posedge clock) disable iff (reset) ctl |=>
      trig_src == ($past(wdata[1:0]) == 2'h3 ? 2'h0 : $past(wdata[1:0]));
  endproperty
  a_src: assert property (p_src)
    else $error("trigger source wrong");
  property p_disp;
    @(posedge clock) disable iff (reset) ctl |-> ##2
      disp.disp_en == $past(wdata[8:5], 2) && disp.y5 == $past(wdata[9], 2)
      && disp.diff == $past(dif, 2);
  endproperty
  a_disp: assert property (p_disp)
    else $error("display setting wrong");
  property p_up;
    @(posedge clock) disable iff (reset) hi_q > 4'h6 |-> eff_prescaled;
  endproperty
  a_up: assert property (p_up)
    else $error("auto mode not prescaled above upper point");
  property p_band;
    @(posedge clock) disable iff (reset)
      bd_q > 4'h6 |-> $stable(eff_prescaled);
  endproperty
  a_band: assert property (p_band)
    else $error("auto mode moved inside hysteresis band");
  property p_commit;
    @(posedge clock) disable iff (reset) acq_start |-> ##[0:1] wave_valid[0];
  endproperty
  a_commit: assert property (p_commit)
    else $error("commit left register zero empty");
endmodule
bind amt_core amt_core_chk u_chk (
  .clock(clock), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
  .acq_start(acq_start), .trig_src(trig_src),
  .eff_prescaled(eff_prescaled), .disp(disp), .freq_mhz(freq_mhz),
  .wave_a(wave_a), .wave_b(wave_b), .wave_valid(wave_valid));

// [bench/amt_front_model.sv]
`timescale 1ns/1ps
// ****
// analog front end and comparator
// ****
module amt_front_model (
  input wire logic clock,
  output amt_pkg::amt_trig_s trig,
  output logic [15:0] sample_a,
  output logic [15:0] sample_b,
  output logic [15:0] freq_mhz
);
  initial begin
    trig = '0;
    sample_a = 16'h1357;
    sample_b = 16'h2468;
    freq_mhz = 16'h0064;
  end
  // words move every cycle so a capture at the wrong edge shows up
  always @(posedge clock) begin
    sample_a <= sample_a + 16'h0003;
    sample_b <= sample_b - 16'h0005;
  end
  task automatic pulse(input int sel, input int len);
    @(posedge clock);
    trig[2 - sel] <= 1'b1;
    repeat (len) @(posedge clock);
    trig <= '0;
    repeat (len) @(posedge clock);
  endtask
  task automatic set_freq(input logic [15:0] f);
    @(posedge clock);
    freq_mhz <= f;
  endtask
endmodule

// [bench/tb_acq_memory_trigger_control.sv]
`timescale 1ns/1ps
module tb_acq_memory_trigger_control;
  logic clock, reset, wr, rd, acq_start, eff_prescaled;
  logic [3:0] addr, wave_valid;
  logic [31:0] wdata, rdata, d;
  logic [15:0] freq_mhz, sample_a, sample_b, hold, ofs_a, ofs_b, a0;
  logic [15:0] wave_a [4];
  logic [15:0] wave_b [4];
  logic [1:0] trig_src;
  logic [16:0] sum_wave;
  amt_pkg::amt_trig_s trig;
  amt_pkg::amt_disp_s disp;
  int fail_count = 0;
  int total_checks = 0;
  int acq_n = 0;
  amt_core dut (
    .clock(clock), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .trig_a(trig.trig_a), .trig_b(trig.trig_b),
    .trig_ext(trig.trig_ext), .freq_mhz(freq_mhz), .sample_a(sample_a),
    .sample_b(sample_b), .acq_start(acq_start), .trig_src(trig_src),
    .eff_prescaled(eff_prescaled), .holdoff_sync_adjust(hold),
    .disp(disp), .ofs_a(ofs_a), .ofs_b(ofs_b), .wave_a(wave_a),
    .wave_b(wave_b), .wave_valid(wave_valid), .sum_wave(sum_wave));
  amt_front_model fm (
    .clock(clock), .trig(trig), .sample_a(sample_a),
    .sample_b(sample_b), .freq_mhz(freq_mhz));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock)
    if (acq_start === 1'b1)
      acq_n++;
  task automatic chk(input string n, input logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
    #1;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [31:0] v);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  // long pulse: rising commits land early, falling ones late
  task automatic fire(input int sel, input int mid, input int tot);
    int n;
    n = acq_n;
    fork
      fm.pulse(sel, 8);
    join_none
    repeat (7) @(posedge clock);
    chk("early commits", 32'(mid), 32'(acq_n - n));
    repeat (14) @(posedge clock);
    chk("commits", 32'(tot), 32'(acq_n - n));
  endtask
  task automatic t_prescale();
    int n;
    n = acq_n;
    wreg(amt_pkg::ADDR_CTRL, 32'h0000_0004);
    repeat (127) fm.pulse(0, 2);
    repeat (6) @(posedge clock);
    chk("prescale 127", 32'h0, 32'(acq_n - n));
    fm.pulse(0, 2);
    repeat (6) @(posedge clock);
    chk("prescale 128", 32'h1, 32'(acq_n - n));
  endtask
  task automatic t_trig();
    for (int s = 0; s < 3; s++) begin
      wreg(amt_pkg::ADDR_CTRL, 32'(s));
      chk("trig_src", 32'(s), 32'(trig_src));
      fire(s, 1, 1);
      fire((s + 1) % 3, 0, 0);
    end
    wreg(amt_pkg::ADDR_CTRL, 32'h0000_0013);
    chk("src fold", 32'h0, 32'(trig_src));
    fire(0, 0, 1);
    wreg(amt_pkg::ADDR_CTRL, 32'h1234_0018);
    rreg(amt_pkg::ADDR_CTRL, d);
    chk("slope bit", 32'h0, 32'(d[4]));
    chk("holdoff", 32'h1234, 32'(hold));
    fire(0, 0, 0);
  endtask
  task automatic t_mem();
    wreg(amt_pkg::ADDR_CTRL, 32'h0);
    wreg(amt_pkg::ADDR_CMD, 32'h0000_0306);
    chk("clear write", 32'h0, 32'(wave_valid[0]));
    fire(0, 1, 1);
    chk("valid0", 32'h1, 32'(wave_valid[0]));
    wreg(amt_pkg::ADDR_CMD, 32'h0000_0301);
    rreg(amt_pkg::ADDR_STATUS, d);
    chk("locked", 32'h1, 32'(d[0]));
    fire(0, 0, 0);
    wreg(amt_pkg::ADDR_CMD, 32'h0000_0304);
    chk("clear locked", 32'h1, 32'(wave_valid[0]));
    wreg(amt_pkg::ADDR_CMD, 32'h0000_0302);
    fire(0, 1, 1);
  endtask
  task automatic t_save();
    a0 = wave_a[0];
    wreg(amt_pkg::ADDR_CMD, 32'h0000_0358);
    chk("copy one", 32'(a0), 32'(wave_a[1]));
    chk("zero kept", 32'(a0), 32'(wave_a[0]));
    chk("valid", 32'hB, 32'(wave_valid));
    wreg(amt_pkg::ADDR_CMD, 32'h0000_0304);
    chk("cleared", 32'hA, 32'(wave_valid));
    wreg(amt_pkg::ADDR_CMD, 32'h0000_0378);
    chk("blanked", 32'h0, 32'(wave_valid));
  endtask
  task automatic t_ofs();
    wreg(amt_pkg::ADDR_CMD, 32'h0005_0300);
    chk("ofs set", 32'h5, 32'(ofs_a));
    wreg(amt_pkg::ADDR_CMD, 32'h0000_0000);
    chk("ofs up", 32'h6, 32'(ofs_a));
    wreg(amt_pkg::ADDR_CMD, 32'h0000_0100);
    chk("ofs down", 32'h5, 32'(ofs_a));
    wreg(amt_pkg::ADDR_CMD, 32'h0001_0200);
    chk("ofs ten", 32'hF, 32'(ofs_a));
    wreg(amt_pkg::ADDR_CMD, 32'hFFFF_0600);
    chk("ofs b ten", 32'hFFF6, 32'(ofs_b));
    chk("ofs a kept", 32'hF, 32'(ofs_a));
  endtask
  task automatic t_disp();
    logic [16:0] s;
    fire(0, 1, 1);
    for (int i = 0; i < 4; i++) begin
      wreg(amt_pkg::ADDR_CTRL, 32'h0000_07E0 | (32'(i) << 11));
      chk("diff", 32'(i == 1 || i == 2), 32'(disp.diff));
      // one inverted channel turns the sum into a difference
      s = (i == 1) ? {1'b0, wave_b[0]} - {1'b0, wave_a[0]}
        : (i == 2) ? {1'b0, wave_a[0]} - {1'b0, wave_b[0]}
        : {1'b0, wave_a[0]} + {1'b0, wave_b[0]};
      chk("sum", 32'(s), 32'(sum_wave));
    end
    chk("disp_en", 32'hF, 32'(disp.disp_en));
    chk("y5", 32'h1, 32'(disp.y5));
    wreg(amt_pkg::ADDR_CTRL, 32'h0);
    chk("sum off", 32'h0, 32'(sum_wave));
  endtask
  task automatic t_auto();
    logic [15:0] f [4] = '{16'h00AA, 16'h009B, 16'h0091, 16'h009B};
    logic [3:0] e = 4'h3;
    wreg(amt_pkg::ADDR_CTRL, 32'h0000_000C);
    for (int i = 0; i < 4; i++) begin
      fm.set_freq(f[i]);
      repeat (10) @(posedge clock);
      chk("auto prescale", 32'(e[i]), 32'(eff_prescaled));
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    reset = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk("disp reset", 32'h1, 32'(disp.disp_en));
    chk("valid reset", 32'h0, 32'(wave_valid));
    rreg(4'hF, d);
    chk("unmapped", 32'h0, d);
    t_prescale();
    t_trig();
    t_mem();
    t_save();
    t_ofs();
    t_disp();
    t_auto();
    report_and_stop();
  end
  initial begin
    #200us;
    fail_count++;
    $display("MISMATCH run expected done seen hang");
    report_and_stop();
  end
endmodule
